// ===== atc_timer.sv
// Async-clocked 8-bit timer with holding registers, prescaler and sync paths
`timescale 1ns/10ps
`include "atc_consts.svh"
module atc_timer #(
  parameter int NUM_HOLD = 5
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic osc_input_pin,
  input wire logic sleep_active,
  input wire logic osc_stop_mode,
  output logic osc_enable,
  output logic osc_port_detach,
  output logic osc_external_mode,
  output logic compare_output_pin_a,
  output logic compare_output_pin_b,
  output logic [2:0] timer_flags,
  output logic wake_request
);
  // ==========================================================
  // Declarations
  logic [2:0] osc_sync_reg;
  logic osc_lvl_reg, osc_edge, osc_edge_d_reg;
  logic async_sel_reg, ext_sel_reg;
  logic [7:0] hold_reg [NUM_HOLD];
  logic [1:0] edge_cnt_reg [NUM_HOLD];
  logic [NUM_HOLD-1:0] busy_reg, load, wr_hit;
  logic [7:0] dest_val [NUM_HOLD];
  logic [7:0] ctl_a_reg, ctl_b_reg, cmp_a_reg, cmp_b_reg, count_reg, copy_reg;
  logic down_reg, src_tick, tick;
  logic [9:0] psc_reg;
  logic [9:0] psc_mask;
  logic [7:0] top;
  logic match_a, match_b, at_top, wrap;
  logic [2:0] ev;
  logic [2:0] pipe_reg [`ATC_FLAG_SYNC_CYC-1];
  logic [2:0] flag_reg;
  logic [1:0] rearm_cnt_reg;
  logic armed, sleep_d_reg, wake_pend_reg;
  atc_pkg::atc_wave_type wave;

  // Compare output next value for any waveform mode
  function automatic logic oc_next(input logic cur, input logic [1:0] com, input atc_pkg::atc_wave_type wv,
                                   input logic match, input logic bottom, input logic dn, input logic tog_ok);
    logic r;
    r = cur;
    case (wv)
      atc_pkg::ATC_NORMAL, atc_pkg::ATC_CTC: begin
        if (match) begin
          r = (com == 2'h1) ? ~cur : (com == 2'h2) ? 1'b0 : (com == 2'h3) ? 1'b1 : cur;
        end
      end
      atc_pkg::ATC_FAST_PWM: begin
        if (com[1] && match) r = ~com[0];
        else if (com[1] && bottom) r = com[0];
        else if (com == 2'h1 && tog_ok && match) r = ~cur;
      end
      atc_pkg::ATC_PHASE_PWM: begin
        if (com[1] && match) r = dn ? ~com[0] : com[0];
        else if (com == 2'h1 && tog_ok && match) r = ~cur;
      end
      default: r = cur;
    endcase
    return r;
  endfunction : oc_next

  // ==========================================================
  // Oscillator pin sampling: edge counts once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_sync_reg <= 3'h0;
      osc_lvl_reg <= 1'b0;
      osc_edge_d_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], osc_input_pin};
      if (osc_sync_reg[1] == osc_sync_reg[2]) osc_lvl_reg <= osc_sync_reg[2];
      osc_edge_d_reg <= osc_edge;
    end
  end
  assign osc_edge = osc_lvl_reg == 1'b0 && osc_sync_reg[1] && osc_sync_reg[2];

  // ==========================================================
  // Status register clock select bits
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      async_sel_reg <= 1'b0;
      ext_sel_reg <= 1'b0;
    end else if (wr_stb && addr == `ATC_OFS_STATUS) begin
      async_sel_reg <= wdata[`ATC_BIT_ASYNC];
      ext_sel_reg <= wdata[`ATC_BIT_EXTCLK];
    end
  end
  assign osc_port_detach = async_sel_reg;
  assign osc_external_mode = ext_sel_reg;
  assign osc_enable = async_sel_reg && !(sleep_active && osc_stop_mode);

  // ==========================================================
  // Holding registers, one per destination, each with its own busy bit
  always_comb begin
    wr_hit[`ATC_H_CTL_B] = wr_stb && addr == `ATC_OFS_CTL_B;
    wr_hit[`ATC_H_CTL_A] = wr_stb && addr == `ATC_OFS_CTL_A;
    wr_hit[`ATC_H_CMP_B] = wr_stb && addr == `ATC_OFS_CMP_B;
    wr_hit[`ATC_H_CMP_A] = wr_stb && addr == `ATC_OFS_CMP_A;
    wr_hit[`ATC_H_COUNT] = wr_stb && addr == `ATC_OFS_COUNT;
    for (int i = 0; i < NUM_HOLD; i++) begin
      load[i] = async_sel_reg ? (busy_reg[i] && osc_edge && edge_cnt_reg[i] == `ATC_LATCH_EDGES - 2'h1)
                              : wr_hit[i];
      dest_val[i] = async_sel_reg ? hold_reg[i] : wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= '0;
      for (int i = 0; i < NUM_HOLD; i++) begin
        hold_reg[i] <= `ATC_RST_BYTE;
        edge_cnt_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < NUM_HOLD; i++) begin
        if (async_sel_reg && wr_hit[i]) begin
          hold_reg[i] <= wdata;
          edge_cnt_reg[i] <= 2'h0;
          busy_reg[i] <= 1'b1;
        end else if (load[i] && async_sel_reg) begin
          busy_reg[i] <= 1'b0;
          edge_cnt_reg[i] <= 2'h0;
        end else if (busy_reg[i] && osc_edge) begin
          edge_cnt_reg[i] <= edge_cnt_reg[i] + 2'h1;
        end
      end
    end
  end

  // ==========================================================
  // Destination registers in the timer domain
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctl_a_reg <= `ATC_RST_BYTE;
      ctl_b_reg <= `ATC_RST_BYTE;
      cmp_a_reg <= `ATC_RST_BYTE;
      cmp_b_reg <= `ATC_RST_BYTE;
    end else begin
      if (load[`ATC_H_CTL_A]) ctl_a_reg <= dest_val[`ATC_H_CTL_A] & `ATC_CTL_A_WMASK;
      if (load[`ATC_H_CTL_B]) ctl_b_reg <= dest_val[`ATC_H_CTL_B];
      if (load[`ATC_H_CMP_A]) cmp_a_reg <= dest_val[`ATC_H_CMP_A];
      if (load[`ATC_H_CMP_B]) cmp_b_reg <= dest_val[`ATC_H_CMP_B];
    end
  end
  assign wave = atc_pkg::atc_wave_type'(ctl_a_reg[1:0]);

  // ==========================================================
  // Prescaler: source tick and divider taps
  assign src_tick = async_sel_reg ? osc_edge : 1'b1;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) psc_reg <= 10'h000;
    else if (wr_stb && addr == `ATC_OFS_GENCTL && wdata[`ATC_BIT_PSR]) psc_reg <= 10'h000;
    else if (src_tick) psc_reg <= psc_reg + 10'h001;
  end
  always_comb begin
    case (ctl_b_reg[2:0])
      3'h2: psc_mask = 10'h007;
      3'h3: psc_mask = 10'h01F;
      3'h4: psc_mask = 10'h03F;
      3'h5: psc_mask = 10'h07F;
      3'h6: psc_mask = 10'h0FF;
      3'h7: psc_mask = 10'h3FF;
      default: psc_mask = 10'h000;
    endcase
  end
  assign tick = src_tick && ctl_b_reg[2:0] != 3'h0 && (psc_reg & psc_mask) == psc_mask;

  // ==========================================================
  // Counter, matches and events
  assign top = (wave == atc_pkg::ATC_CTC || ctl_b_reg[`ATC_BIT_WGM2]) ? cmp_a_reg : `ATC_TOP_MAX;
  assign at_top = count_reg == top;
  assign match_a = count_reg == cmp_a_reg && !busy_reg[`ATC_H_CMP_A] && !busy_reg[`ATC_H_COUNT];
  assign match_b = count_reg == cmp_b_reg && !busy_reg[`ATC_H_CMP_B] && !busy_reg[`ATC_H_COUNT];
  assign wrap = (wave == atc_pkg::ATC_FAST_PWM || wave == atc_pkg::ATC_CTC) ? at_top
              : (wave == atc_pkg::ATC_NORMAL) && count_reg == `ATC_TOP_MAX;
  always_comb begin
    ev[0] = tick && ((wave == atc_pkg::ATC_PHASE_PWM) ? (down_reg && count_reg == `ATC_BOTTOM)
                     : (wave == atc_pkg::ATC_FAST_PWM) ? at_top : count_reg == `ATC_TOP_MAX);
    ev[1] = tick && match_a;
    ev[2] = tick && match_b;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= `ATC_BOTTOM;
      down_reg <= 1'b0;
    end else if (load[`ATC_H_COUNT]) begin
      count_reg <= dest_val[`ATC_H_COUNT];
    end else if (tick) begin
      if (wave == atc_pkg::ATC_PHASE_PWM) begin
        if (!down_reg && at_top) down_reg <= 1'b1;
        else if (down_reg && count_reg == `ATC_BOTTOM) down_reg <= 1'b0;
        count_reg <= (down_reg ? count_reg != `ATC_BOTTOM : at_top) ? count_reg - 8'h01 : count_reg + 8'h01;
      end else begin
        count_reg <= wrap ? `ATC_BOTTOM : count_reg + 8'h01;
      end
    end
  end

  // Compare pins change only on timer ticks, with no CPU-side resync
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compare_output_pin_a <= 1'b0;
      compare_output_pin_b <= 1'b0;
    end else if (tick) begin
      compare_output_pin_a <= oc_next(compare_output_pin_a, ctl_a_reg[7:6], wave, match_a, wrap, down_reg,
                                      ctl_b_reg[`ATC_BIT_WGM2]);
      compare_output_pin_b <= oc_next(compare_output_pin_b, ctl_a_reg[5:4], wave, match_b, wrap, down_reg, 1'b0);
    end
  end

  // ==========================================================
  // Count read copy refreshed after each oscillator rising edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) copy_reg <= `ATC_BOTTOM;
    else if (!async_sel_reg || osc_edge_d_reg) copy_reg <= count_reg;
  end

  // ==========================================================
  // Flag path into the CPU side; a new event beats a software clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 3'h0;
      for (int i = 0; i < `ATC_FLAG_SYNC_CYC - 1; i++) pipe_reg[i] <= 3'h0;
    end else begin
      pipe_reg[0] <= ev;
      for (int i = 1; i < `ATC_FLAG_SYNC_CYC - 1; i++) pipe_reg[i] <= pipe_reg[i-1];
      flag_reg <= (flag_reg & ~((wr_stb && addr == `ATC_OFS_FLAGS) ? wdata[2:0] : 3'h0))
                | pipe_reg[`ATC_FLAG_SYNC_CYC-2];
    end
  end
  assign timer_flags = flag_reg;

  // ==========================================================
  // Wake request: issued on the tick after the event, re-armed after two oscillator rising edges
  assign armed = rearm_cnt_reg == `ATC_REARM_EDGES;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sleep_d_reg <= 1'b0;
      rearm_cnt_reg <= `ATC_REARM_EDGES;
      wake_pend_reg <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_active;
      wake_request <= 1'b0;
      if (sleep_d_reg && !sleep_active) rearm_cnt_reg <= 2'h0;
      else if (!armed && osc_edge) rearm_cnt_reg <= rearm_cnt_reg + 2'h1;
      if (sleep_active && armed && |ev) wake_pend_reg <= 1'b1;
      else if (wake_pend_reg && tick) begin
        wake_pend_reg <= 1'b0;
        wake_request <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdata <= 8'h00;
    else if (rd_stb) begin
      case (addr)
        `ATC_OFS_CTL_A: rdata <= ctl_a_reg;
        `ATC_OFS_CTL_B: rdata <= ctl_b_reg;
        `ATC_OFS_COUNT: rdata <= copy_reg;
        `ATC_OFS_CMP_A: rdata <= cmp_a_reg;
        `ATC_OFS_CMP_B: rdata <= cmp_b_reg;
        `ATC_OFS_STATUS: rdata <= {1'b0, ext_sel_reg, async_sel_reg, busy_reg};
        `ATC_OFS_FLAGS: rdata <= {5'h00, flag_reg};
        default: rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_busy_set;
    async_sel_reg && wr_hit[`ATC_H_COUNT] |=> busy_reg[`ATC_H_COUNT];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set on write");
  property p_latch;
    load[`ATC_H_CMP_A] && async_sel_reg && !wr_hit[`ATC_H_CMP_A] |=> !busy_reg[`ATC_H_CMP_A]
      && cmp_a_reg == $past(hold_reg[`ATC_H_CMP_A]);
  endproperty
  a_latch: assert property (p_latch) else $error("held value not latched");
  property p_indep;
    async_sel_reg && busy_reg[`ATC_H_CMP_B] && !load[`ATC_H_CMP_B] && wr_hit[`ATC_H_COUNT]
      |=> busy_reg[`ATC_H_CMP_B] && $stable(hold_reg[`ATC_H_CMP_B]);
  endproperty
  a_indep: assert property (p_indep) else $error("write disturbed other transfer");
  property p_suppress;
    busy_reg[`ATC_H_COUNT] |-> !ev[1] && !ev[2];
  endproperty
  a_suppress: assert property (p_suppress) else $error("match during transfer");
  property p_flag_delay;
    ev[0] |-> ##3 flag_reg[0];
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag delay wrong");
  property p_stop;
    ctl_b_reg[2:0] == 3'h0 |-> !tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_psr;
    wr_stb && addr == `ATC_OFS_GENCTL && wdata[`ATC_BIT_PSR] |=> psc_reg == 10'h000;
  endproperty
  a_psr: assert property (p_psr) else $error("prescaler not reset");
  property p_reserved;
    ctl_a_reg[3:2] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_pin;
    !tick |=> $stable(compare_output_pin_a);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved off tick");
  property p_copy;
    async_sel_reg && !osc_edge_d_reg && $stable(async_sel_reg) |=> $stable(copy_reg);
  endproperty
  a_copy: assert property (p_copy) else $error("copy moved between edges");
  property p_osc_off;
    async_sel_reg && sleep_active && osc_stop_mode |-> !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs in stop mode");
  c_transfer: cover property (async_sel_reg && wr_hit[`ATC_H_CMP_A] ##[1:1000] load[`ATC_H_CMP_A]);
  c_wake: cover property (wake_request);
  c_match: cover property (ev[1] ##3 flag_reg[1]);
endmodule : atc_timer

// ===== atc_consts.svh
// Register offsets, field positions, reset values and counts of the async timer
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH
`define ATC_OFS_CTL_A 8'hB0
`define ATC_OFS_CTL_B 8'hB1
`define ATC_OFS_COUNT 8'hB2
`define ATC_OFS_CMP_A 8'hB3
`define ATC_OFS_CMP_B 8'hB4
`define ATC_OFS_STATUS 8'hB6
`define ATC_OFS_GENCTL 8'h43
`define ATC_OFS_FLAGS 8'h37
`define ATC_RST_BYTE 8'h00
`define ATC_CTL_A_WMASK 8'hF3
`define ATC_BIT_EXTCLK 6
`define ATC_BIT_ASYNC 5
`define ATC_BIT_PSR 1
`define ATC_BIT_WGM2 3
`define ATC_H_CTL_B 0
`define ATC_H_CTL_A 1
`define ATC_H_CMP_B 2
`define ATC_H_CMP_A 3
`define ATC_H_COUNT 4
`define ATC_LATCH_EDGES 2'h2
`define ATC_REARM_EDGES 2'h2
`define ATC_FLAG_SYNC_CYC 3
`define ATC_TOP_MAX 8'hFF
`define ATC_BOTTOM 8'h00
`endif

// ===== atc_pkg.sv
// Types shared by the async timer
package atc_pkg;
  // Low waveform mode field, in field-code order
  typedef enum logic [1:0] {ATC_NORMAL, ATC_PHASE_PWM, ATC_CTC, ATC_FAST_PWM} atc_wave_type;
endpackage : atc_pkg

// ===== atc_osc_model.sv
// Behavioural low-frequency oscillator or external clock feeding the timer pin
`timescale 1ns/10ps
module atc_osc_model #(
  parameter realtime HALF_NS = 25.3
) (
  enable,
  osc_input_pin
);
  input wire logic enable;
  output logic osc_input_pin;

  // ==========================================
  // Oscillator
  // Period of 50.6 ns keeps the system clock well above four times this rate
  // Pin rests low while the oscillator is not enabled
  initial begin
    osc_input_pin = 1'b0;
    forever begin
      if (enable === 1'b1) begin
        #(HALF_NS) osc_input_pin = ~osc_input_pin;
      end else begin
        osc_input_pin = 1'b0;
        @(posedge enable);
      end
    end
  end
endmodule : atc_osc_model

// ===== testbench.sv
// Self-checking bench for the async timer
`timescale 1ns/10ps
`include "atc_consts.svh"
module testbench;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} atc_row_type;
  logic clock, arst_n, wr_stb, rd_stb, sleep_active, osc_stop_mode;
  logic [7:0] addr, wdata, rdata, v0, v1;
  logic osc_input_pin, osc_enable, osc_port_detach, osc_external_mode, pin_a, pin_b, wake_request, pa, pb;
  logic [2:0] timer_flags;
  int err_total, samples_checked, n;
  int divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  atc_row_type rows [7] = '{'{8'hB0, 8'hFF, 8'hF3}, '{8'hB0, 8'hA1, 8'hA1}, '{8'hB3, 8'h5A, 8'h5A},
    '{8'hB4, 8'hC3, 8'hC3}, '{8'hB1, 8'h00, 8'h00}, '{8'hB5, 8'hFF, 8'h00}, '{8'hB0, 8'h00, 8'h00}};

  // ==========================================
  // Design and oscillator source
  atc_timer i_dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .osc_input_pin(osc_input_pin), .sleep_active(sleep_active),
    .osc_stop_mode(osc_stop_mode), .osc_enable(osc_enable), .osc_port_detach(osc_port_detach),
    .osc_external_mode(osc_external_mode), .compare_output_pin_a(pin_a), .compare_output_pin_b(pin_b),
    .timer_flags(timer_flags), .wake_request(wake_request));
  atc_osc_model i_osc (.enable(osc_enable), .osc_input_pin(osc_input_pin));

  // ==========================================
  // Clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================
  // Bus cycles and comparisons
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected run of about 7000 cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sleep_active = 1'b0;
    osc_stop_mode = 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    // Reset values
    rd(`ATC_OFS_CTL_A, v0);
    chk8("control a reset", 8'h00, v0);
    rd(`ATC_OFS_STATUS, v0);
    chk8("status reset", 8'h00, v0);
    chk1("port detach reset", 1'b0, osc_port_detach);
    // Table of direct writes in sync mode
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v0);
      chk8("register readback", rows[i].e, v0);
    end
    wr(`ATC_OFS_GENCTL, 8'h02);
    // Count step per clock select, sync mode
    for (int s = 0; s < 8; s++) begin
      wr(`ATC_OFS_CTL_B, 8'(s));
      repeat (8) @(posedge clock);
      rd(`ATC_OFS_COUNT, v0);
      repeat ((s == 0) ? 12 : 4 * divs[s] - 2) @(posedge clock);
      rd(`ATC_OFS_COUNT, v1);
      chk8("count step", (s == 0) ? 8'h00 : 8'h04, v1 - v0);
    end
    // Toggle output A on compare match and sticky flag
    wr(`ATC_OFS_CTL_B, 8'h01);
    wr(`ATC_OFS_CTL_A, 8'h40);
    wr(`ATC_OFS_CMP_A, 8'h80);
    @(negedge clock);
    pa = pin_a;
    n = 0;
    while (pin_a === pa && n < 600) begin
      @(negedge clock);
      n++;
    end
    chk1("compare pin a", ~pa, pin_a);
    n = 0;
    while (timer_flags[1] !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk1("compare a flag", 1'b1, timer_flags[1]);
    @(posedge clock);
    wr(`ATC_OFS_FLAGS, 8'h07);
    chk1("compare a flag cleared", 1'b0, timer_flags[1]);
    // Toggle output B on its own compare match
    wr(`ATC_OFS_CTL_A, 8'h10);
    @(negedge clock);
    pb = pin_b;
    n = 0;
    while (pin_b === pb && n < 600) begin
      @(negedge clock);
      n++;
    end
    chk1("compare pin b", ~pb, pin_b);
    @(posedge clock);
    // Clear-on-match mode keeps the count at or below compare A
    wr(`ATC_OFS_CMP_A, 8'h03);
    wr(`ATC_OFS_CTL_A, 8'h02);
    wr(`ATC_OFS_COUNT, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rd(`ATC_OFS_COUNT, v0);
      chk1("count within top", 1'b1, v0 <= 8'h03);
    end
    wr(`ATC_OFS_CTL_A, 8'h00);
    // Switch to async clocking in the safe order
    wr(`ATC_OFS_CTL_B, 8'h00);
    wr(`ATC_OFS_STATUS, 8'h20);
    chk1("port detach", 1'b1, osc_port_detach);
    chk1("osc enable", 1'b1, osc_enable);
    wr(`ATC_OFS_CMP_A, 8'h40);
    wr(`ATC_OFS_CMP_B, 8'h0A);
    wr(`ATC_OFS_COUNT, 8'h00);
    wr(`ATC_OFS_CTL_B, 8'h01);
    rd(`ATC_OFS_STATUS, v0);
    chk8("status busy", 8'h3D, v0);
    n = 0;
    while (v0[4:0] != 5'h00 && n < 200) begin
      rd(`ATC_OFS_STATUS, v0);
      n++;
    end
    chk8("status idle", 8'h20, v0);
    rd(`ATC_OFS_CMP_A, v0);
    chk8("compare a latched", 8'h40, v0);
    rd(`ATC_OFS_CMP_B, v0);
    chk8("compare b latched", 8'h0A, v0);
    wr(`ATC_OFS_FLAGS, 8'h07);
    // Power-save sleep after busy cleared, woken by the timer
    sleep_active <= 1'b1;
    n = 0;
    while (wake_request !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    chk1("wake request", 1'b1, wake_request);
    @(posedge clock);
    sleep_active <= 1'b0;
    // After waking, write a control register and wait for its busy bit before reading the count
    wr(`ATC_OFS_CTL_B, 8'h01);
    n = 0;
    rd(`ATC_OFS_STATUS, v0);
    while (v0[`ATC_H_CTL_B] && n < 200) begin
      rd(`ATC_OFS_STATUS, v0);
      n++;
    end
    rd(`ATC_OFS_COUNT, v0);
    chk1("count past wake match", 1'b1, v0 > 8'h0A);
    repeat (40) @(posedge clock);
    // Power-down stops the oscillator
    sleep_active <= 1'b1;
    osc_stop_mode <= 1'b1;
    @(posedge clock);
    #1 chk1("osc stopped", 1'b0, osc_enable);
    @(posedge clock);
    sleep_active <= 1'b0;
    osc_stop_mode <= 1'b0;
    @(posedge clock);
    wr(`ATC_OFS_STATUS, 8'h60);
    chk1("external clock mode", 1'b1, osc_external_mode);
    // Reset in mid-run returns to the system clock source
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd(`ATC_OFS_STATUS, v0);
    chk8("status after reset", 8'h00, v0);
    chk1("port detach after reset", 1'b0, osc_port_detach);
    tally_and_finish();
  end
endmodule : testbench
